// [common/ci_ctrl_pkg.sv]
// Constants and types shared by the framer control register group
package ci_ctrl_pkg;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam int          ADDR_W                = 12;
    localparam logic [11:0] OFS_INTERRUPT_CONTROL = 12'h110;
    localparam logic [11:0] OFS_HDLC_SELECT       = 12'h114;
    localparam logic [11:0] OFS_FRAMING           = 12'h118;
    localparam logic [11:0] OFS_CI_ALARM          = 12'h11c;
    localparam logic [11:0] OFS_IRQ_STATUS        = 12'h120;
    localparam logic [11:0] OFS_IRQ_ENABLE        = 12'h124;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int         BIT_BLOCK_GATE   = 0;
    localparam int         BIT_AUTOCLEAR    = 1;
    localparam int         BIT_CLEAR_POLICY = 2;
    localparam int         BIT_ESF          = 0;
    localparam int         ST_AIS_CI        = 0;
    localparam int         ST_RAI_CI        = 1;
    localparam int         NUM_EVENTS       = 2;
    localparam logic [7:0] RST_REG          = 8'h00;

    // ****************************************************************
    // Codes
    // ****************************************************************
    localparam logic [1:0] CI_OFF  = 2'h0;
    localparam logic [1:0] CI_AIS  = 2'h1;
    localparam logic [1:0] CI_RAI  = 2'h2;
    localparam logic [1:0] HDLC_2  = 2'h1;
    localparam logic [1:0] HDLC_3  = 2'h2;
    localparam logic [2:0] HSEL_1  = 3'h1;
    localparam logic [2:0] HSEL_2  = 3'h2;
    localparam logic [2:0] HSEL_3  = 3'h4;

    // ****************************************************************
    // Alarm patterns and timing
    // ****************************************************************
    localparam logic [15:0] AIS_CI_SIGNATURE   = 16'h7cff;
    localparam logic [15:0] RAI_MESSAGE        = 16'h00ff;
    localparam logic [15:0] RAI_CI_SIGNATURE   = 16'h3eff;
    localparam int          SIG_BITS           = 16;
    localparam int          AIS_CI_PERIOD_BITS = 386;
    localparam int          CLK_KHZ            = 200000;
    localparam int          RAI_MSG_MS         = 990;
    localparam int          RAI_SIG_MS         = 90;
    localparam int          RAI_MSG_CYCLES     = RAI_MSG_MS * CLK_KHZ;
    localparam int          RAI_SIG_CYCLES     = RAI_SIG_MS * CLK_KHZ;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [3:0] {
        GEN_IDLE    = 4'h1,
        GEN_AIS     = 4'h2,
        GEN_RAI_MSG = 4'h4,
        GEN_RAI_SIG = 4'h8
    } gen_state_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [11:0] adr;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;

    typedef struct packed {
        logic                  ack;
        logic [7:0]            rdat;
        logic                  irq;
        logic [NUM_EVENTS-1:0] status;
        logic [NUM_EVENTS-1:0] enable;
        logic [2:0]            interrupt_control;
        logic [1:0]            hdlc;
        logic                  esf;
        logic [3:0]            ci;
        logic [2:0]            hsel;
        logic                  ais_det;
        logic                  rai_det;
    } ctl_state_t;

endpackage

// [src/ci_alarm_gen.sv]
// Customer-installation alarm pattern generator
`timescale 1ns/1ps
module ci_alarm_gen #(
    parameter int MSG_CYCLES = ci_ctrl_pkg::RAI_MSG_CYCLES,
    parameter int SIG_CYCLES = ci_ctrl_pkg::RAI_SIG_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [1:0] mode_i,
    input  wire logic       bit_tick_i,
    output logic            tx_active_o,
    output logic            tx_data_o
);

    localparam int TW = $clog2(MSG_CYCLES > SIG_CYCLES ? MSG_CYCLES : SIG_CYCLES) + 1;

    typedef struct packed {
        ci_ctrl_pkg::gen_state_t state;
        logic [8:0]              bitcnt;
        logic [TW-1:0]           timer;
        logic                    active;
        logic                    data;
    } gen_t;

    gen_t st_reg;
    gen_t st_next;

    generate
        if (MSG_CYCLES < 2 || SIG_CYCLES < 2) begin : g_bad
            $error("RAI-CI phase lengths must be at least two cycles");
        end
    endgenerate

    // ****************************************************************
    // Pattern sequencing
    // ****************************************************************
    always_comb begin
        st_next = st_reg;
        case (st_reg.state)
            ci_ctrl_pkg::GEN_IDLE: begin
                st_next.bitcnt = 9'h000;
                st_next.timer  = '0;
                st_next.data   = 1'b0;
                if (mode_i == ci_ctrl_pkg::CI_AIS) begin // [R7]
                    st_next.state = ci_ctrl_pkg::GEN_AIS;
                end else if (mode_i == ci_ctrl_pkg::CI_RAI) begin
                    st_next.state = ci_ctrl_pkg::GEN_RAI_MSG;
                end
            end
            ci_ctrl_pkg::GEN_AIS: begin
                if (mode_i != ci_ctrl_pkg::CI_AIS) begin
                    st_next.state = ci_ctrl_pkg::GEN_IDLE;
                end else if (bit_tick_i) begin
                    // All ones with the signature, low bit first [R8]
                    st_next.data = (st_reg.bitcnt < 9'(ci_ctrl_pkg::SIG_BITS)) ?
                        ci_ctrl_pkg::AIS_CI_SIGNATURE[st_reg.bitcnt[3:0]] : 1'b1;
                    st_next.bitcnt = (st_reg.bitcnt == 9'(ci_ctrl_pkg::AIS_CI_PERIOD_BITS - 1)) ?
                        9'h000 : st_reg.bitcnt + 9'h001;
                end
            end
            ci_ctrl_pkg::GEN_RAI_MSG, ci_ctrl_pkg::GEN_RAI_SIG: begin
                if (mode_i != ci_ctrl_pkg::CI_RAI) begin
                    st_next.state = ci_ctrl_pkg::GEN_IDLE;
                end else begin
                    st_next.timer = st_reg.timer + TW'(1);
                    // Message then signature phase, repeating [R9]
                    if (st_reg.state == ci_ctrl_pkg::GEN_RAI_MSG && st_reg.timer == TW'(MSG_CYCLES - 1)) begin
                        st_next.state = ci_ctrl_pkg::GEN_RAI_SIG;
                        st_next.timer = '0;
                    end
                    if (st_reg.state == ci_ctrl_pkg::GEN_RAI_SIG && st_reg.timer == TW'(SIG_CYCLES - 1)) begin
                        st_next.state = ci_ctrl_pkg::GEN_RAI_MSG;
                        st_next.timer = '0;
                    end
                    if (bit_tick_i) begin
                        // 16-bit codes repeated, low bit first [R10]
                        st_next.data = (st_reg.state == ci_ctrl_pkg::GEN_RAI_MSG) ?
                            ci_ctrl_pkg::RAI_MESSAGE[st_reg.bitcnt[3:0]] :
                            ci_ctrl_pkg::RAI_CI_SIGNATURE[st_reg.bitcnt[3:0]];
                        st_next.bitcnt = {5'h00, st_reg.bitcnt[3:0] + 4'h1};
                    end
                end
            end
            default: begin
                st_next.state = ci_ctrl_pkg::GEN_IDLE;
            end
        endcase
        st_next.active = (st_next.state != ci_ctrl_pkg::GEN_IDLE);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '{state: ci_ctrl_pkg::GEN_IDLE, bitcnt: 9'h000, timer: '0, active: 1'b0, data: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign tx_active_o = st_reg.active;
    assign tx_data_o   = st_reg.data;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ais_sig_bit8: assert property ( // [R8]
        st_reg.state == ci_ctrl_pkg::GEN_AIS && mode_i == ci_ctrl_pkg::CI_AIS && bit_tick_i
        && st_reg.bitcnt == 9'h008 |=> tx_data_o == ci_ctrl_pkg::AIS_CI_SIGNATURE[8])
        else $error("AIS-CI signature bit wrong");
    a_ais_ones: assert property ( // [R8]
        st_reg.state == ci_ctrl_pkg::GEN_AIS && mode_i == ci_ctrl_pkg::CI_AIS && bit_tick_i
        && st_reg.bitcnt >= 9'h010 |=> tx_data_o)
        else $error("AIS-CI fill not all ones");
    a_ais_period: assert property ( // [R8]
        st_reg.state == ci_ctrl_pkg::GEN_AIS && mode_i == ci_ctrl_pkg::CI_AIS && bit_tick_i
        && st_reg.bitcnt == 9'h181 |=> st_reg.bitcnt == 9'h000)
        else $error("AIS-CI period wrong");
    a_rai_phase: assert property ( // [R9]
        st_reg.state == ci_ctrl_pkg::GEN_RAI_MSG && mode_i == ci_ctrl_pkg::CI_RAI
        && st_reg.timer == TW'(MSG_CYCLES - 1) |=> st_reg.state == ci_ctrl_pkg::GEN_RAI_SIG)
        else $error("RAI-CI message phase length wrong");
    a_rai_sig_bit: assert property ( // [R10]
        st_reg.state == ci_ctrl_pkg::GEN_RAI_SIG && mode_i == ci_ctrl_pkg::CI_RAI && bit_tick_i
        && st_reg.bitcnt[3:0] == 4'h9 |=> tx_data_o == ci_ctrl_pkg::RAI_CI_SIGNATURE[9])
        else $error("RAI-CI signature bit wrong");
    a_gen_off: assert property ( // [R7]
        mode_i != ci_ctrl_pkg::CI_AIS && mode_i != ci_ctrl_pkg::CI_RAI |=> !tx_active_o)
        else $error("Alarm sent while disabled");
    c_rai_sig: cover property (st_reg.state == ci_ctrl_pkg::GEN_RAI_SIG);
    c_ais_wrap: cover property (st_reg.state == ci_ctrl_pkg::GEN_AIS && st_reg.bitcnt == 9'h181);

endmodule

// [src/framer_irq_hdlc_ci_alarm_ctrl.sv]
// Framer interrupt, HDLC select and CI alarm control register group
//
// Summary of operation
// R1 - Policy bit: status clears on read or write
// R2 - Autoclear set: status read clears matching enables
// R3 - Autoclear clear: enables kept after status read
// R4 - Block gate low suppresses every interrupt
// R5 - HDLC select: 00/11 one, 01 two, 10 three
// R6 - Alarm transmit only in T1 ESF framing
// R7 - Transmit select: 01 AIS-CI, 10 RAI-CI, else off
// R8 - AIS-CI: ones, 16-bit signature every 386 bits
// R9 - RAI-CI: 0.99 s message, 90 ms signature
// R10 - Both RAI codes 16 bits, low bit first
// R11 - Alarm detect select applies only in ESF
// R12 - Detect select: 01 AIS-CI, 10 RAI-CI, else off
// R13 - Interrupt needs gate and enabled set flag
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
module framer_irq_hdlc_ci_alarm_ctrl #(
    parameter int RAI_MSG_CYCLES = ci_ctrl_pkg::RAI_MSG_CYCLES,
    parameter int RAI_SIG_CYCLES = ci_ctrl_pkg::RAI_SIG_CYCLES
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire ci_ctrl_pkg::wb_req_t wb_req_i,
    output ci_ctrl_pkg::wb_rsp_t      wb_rsp_o,
    input  wire logic                 rx_ais_ci_seen_i,
    input  wire logic                 rx_rai_ci_seen_i,
    input  wire logic                 tx_bit_tick_i,
    output logic                      irq_o,
    output logic [2:0]                hdlc_sel_o,
    output logic                      ais_ci_detect_en_o,
    output logic                      rai_ci_detect_en_o,
    output logic                      tx_ci_active_o,
    output logic                      tx_ci_data_o
);

    ci_ctrl_pkg::ctl_state_t st_reg;
    ci_ctrl_pkg::ctl_state_t st_next;

    logic       req;
    logic       wr;
    logic       rd_status;
    logic [1:0] event_set;
    logic [1:0] status_clr;
    logic [1:0] enable_clr;
    logic [1:0] tx_mode;
    logic       irq_cause;
    logic [7:0] wdat;

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    assign req       = wb_req_i.cyc && wb_req_i.stb && !st_reg.ack;
    assign wr        = req && wb_req_i.we && wb_req_i.sel[0];
    assign wdat      = wb_req_i.dat[7:0];
    assign rd_status = req && !wb_req_i.we && wb_req_i.adr == ci_ctrl_pkg::OFS_IRQ_STATUS;

    // Detected alarms raise flags only while detection is enabled
    assign event_set[ci_ctrl_pkg::ST_AIS_CI] = rx_ais_ci_seen_i && st_reg.ais_det;
    assign event_set[ci_ctrl_pkg::ST_RAI_CI] = rx_rai_ci_seen_i && st_reg.rai_det;

    // Transmit select forced off outside ESF [R6]
    assign tx_mode   = st_reg.esf ? st_reg.ci[3:2] : ci_ctrl_pkg::CI_OFF;
    assign irq_cause = st_reg.interrupt_control[ci_ctrl_pkg::BIT_BLOCK_GATE] && |(st_reg.status & st_reg.enable);

    // ****************************************************************
    // Register file
    // ****************************************************************
    always_comb begin
        st_next    = st_reg;
        status_clr = 2'h0;
        enable_clr = 2'h0;
        st_next.ack  = req;
        st_next.rdat = 8'h00;
        if (req && !wb_req_i.we) begin
            case (wb_req_i.adr)
                ci_ctrl_pkg::OFS_INTERRUPT_CONTROL: begin
                    st_next.rdat = {5'h00, st_reg.interrupt_control};
                end
                ci_ctrl_pkg::OFS_HDLC_SELECT: begin
                    st_next.rdat = {6'h00, st_reg.hdlc};
                end
                ci_ctrl_pkg::OFS_FRAMING: begin
                    st_next.rdat = {7'h00, st_reg.esf};
                end
                ci_ctrl_pkg::OFS_CI_ALARM: begin
                    st_next.rdat = {4'h0, st_reg.ci};
                end
                ci_ctrl_pkg::OFS_IRQ_STATUS: begin
                    st_next.rdat = {6'h00, st_reg.status};
                    if (!st_reg.interrupt_control[ci_ctrl_pkg::BIT_CLEAR_POLICY]) begin
                        status_clr = st_reg.status; // [R1]
                    end
                    if (st_reg.interrupt_control[ci_ctrl_pkg::BIT_AUTOCLEAR]) begin
                        enable_clr = st_reg.status; // [R2] [R3]
                    end
                end
                ci_ctrl_pkg::OFS_IRQ_ENABLE: begin
                    st_next.rdat = {6'h00, st_reg.enable};
                end
                default: begin
                    st_next.rdat = 8'h00;
                end
            endcase
        end
        if (wr) begin
            case (wb_req_i.adr)
                ci_ctrl_pkg::OFS_INTERRUPT_CONTROL: begin
                    st_next.interrupt_control = wdat[2:0];
                end
                ci_ctrl_pkg::OFS_HDLC_SELECT: begin
                    st_next.hdlc = wdat[1:0];
                end
                ci_ctrl_pkg::OFS_FRAMING: begin
                    st_next.esf = wdat[ci_ctrl_pkg::BIT_ESF];
                end
                ci_ctrl_pkg::OFS_CI_ALARM: begin
                    st_next.ci = wdat[3:0];
                end
                ci_ctrl_pkg::OFS_IRQ_STATUS: begin
                    if (st_reg.interrupt_control[ci_ctrl_pkg::BIT_CLEAR_POLICY]) begin
                        status_clr = wdat[1:0]; // [R1]
                    end
                end
                ci_ctrl_pkg::OFS_IRQ_ENABLE: begin
                    st_next.enable = wdat[1:0];
                end
                default: begin
                    st_next.ci = st_reg.ci;
                end
            endcase
        end
        // New events win over a clear in the same cycle
        st_next.status = (st_reg.status & ~status_clr) | event_set;
        st_next.enable = st_next.enable & ~enable_clr; // [R2]
        st_next.irq    = irq_cause; // [R4] [R13]
        case (st_reg.hdlc)
            ci_ctrl_pkg::HDLC_2: st_next.hsel = ci_ctrl_pkg::HSEL_2; // [R5]
            ci_ctrl_pkg::HDLC_3: st_next.hsel = ci_ctrl_pkg::HSEL_3; // [R5]
            default:             st_next.hsel = ci_ctrl_pkg::HSEL_1; // [R5]
        endcase
        st_next.ais_det = st_reg.esf && st_reg.ci[1:0] == ci_ctrl_pkg::CI_AIS; // [R11] [R12]
        st_next.rai_det = st_reg.esf && st_reg.ci[1:0] == ci_ctrl_pkg::CI_RAI; // [R11] [R12]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '{ack: 1'b0, rdat: ci_ctrl_pkg::RST_REG, irq: 1'b0, status: 2'h0, enable: 2'h0,
                        interrupt_control: 3'h0, hdlc: 2'h0, esf: 1'b0, ci: 4'h0, hsel: ci_ctrl_pkg::HSEL_1,
                        ais_det: 1'b0, rai_det: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_rsp_o.ack       = st_reg.ack;
    assign wb_rsp_o.dat       = {24'h000000, st_reg.rdat};
    assign irq_o              = st_reg.irq;
    assign hdlc_sel_o         = st_reg.hsel;
    assign ais_ci_detect_en_o = st_reg.ais_det;
    assign rai_ci_detect_en_o = st_reg.rai_det;

    // ****************************************************************
    // Alarm generator
    // ****************************************************************
    ci_alarm_gen #(
        .MSG_CYCLES (RAI_MSG_CYCLES),
        .SIG_CYCLES (RAI_SIG_CYCLES)
    ) u_gen (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .mode_i      (tx_mode),
        .bit_tick_i  (tx_bit_tick_i),
        .tx_active_o (tx_ci_active_o),
        .tx_data_o   (tx_ci_data_o)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_read_clears: assert property ( // [R1]
        rd_status && !st_reg.interrupt_control[ci_ctrl_pkg::BIT_CLEAR_POLICY] |=> st_reg.status == $past(event_set))
        else $error("Status not cleared by read");
    a_wc_read_holds: assert property ( // [R1]
        rd_status && st_reg.interrupt_control[ci_ctrl_pkg::BIT_CLEAR_POLICY]
        |=> (st_reg.status & $past(st_reg.status)) == $past(st_reg.status))
        else $error("Status cleared by read in write-clear mode");
    a_write_clears: assert property ( // [R1]
        wr && wb_req_i.adr == ci_ctrl_pkg::OFS_IRQ_STATUS && st_reg.interrupt_control[ci_ctrl_pkg::BIT_CLEAR_POLICY]
        && wdat[1:0] == 2'h3 ##1 st_reg.ack |-> st_reg.status == $past(event_set))
        else $error("Status not cleared by write");
    a_enable_autoclr: assert property ( // [R2]
        rd_status && st_reg.interrupt_control[ci_ctrl_pkg::BIT_AUTOCLEAR] |=> (st_reg.enable & $past(st_reg.status)) == 2'h0)
        else $error("Enable not cleared after status read");
    a_enable_kept: assert property ( // [R3]
        rd_status && !st_reg.interrupt_control[ci_ctrl_pkg::BIT_AUTOCLEAR] |=> st_reg.enable == $past(st_reg.enable))
        else $error("Enable changed after status read");
    a_gate_blocks: assert property ( // [R4]
        !st_reg.interrupt_control[ci_ctrl_pkg::BIT_BLOCK_GATE] |=> !irq_o)
        else $error("Interrupt while block gate is off");
    a_irq_cause: assert property ( // [R13]
        irq_o |-> $past(irq_cause)) else $error("Interrupt without enabled flag");
    a_irq_follows: assert property ( // [R13]
        irq_cause && !req |=> irq_o ##1 irq_o) else $error("Interrupt missing");
    a_hdlc_one: assert property ( // [R5]
        st_reg.hdlc == 2'h0 || st_reg.hdlc == 2'h3 |=> hdlc_sel_o == ci_ctrl_pkg::HSEL_1)
        else $error("HDLC controller one not selected");
    a_hdlc_three: assert property ( // [R5]
        st_reg.hdlc == 2'h2 |=> hdlc_sel_o == ci_ctrl_pkg::HSEL_3)
        else $error("HDLC controller three not selected");
    a_tx_esf_only: assert property ( // [R6]
        !st_reg.esf |=> !tx_ci_active_o) else $error("Alarm sent outside ESF");
    a_det_esf_only: assert property ( // [R11]
        !st_reg.esf |=> !ais_ci_detect_en_o && !rai_ci_detect_en_o)
        else $error("Detection enabled outside ESF");
    a_det_rai: assert property ( // [R12]
        st_reg.esf && st_reg.ci[1:0] == ci_ctrl_pkg::CI_RAI |=> rai_ci_detect_en_o && !ais_ci_detect_en_o)
        else $error("RAI-CI detection not enabled");
    a_no_lost_event: assert property ( // [R1]
        |event_set |=> (st_reg.status & $past(event_set)) == $past(event_set))
        else $error("Event lost");
    c_irq: cover property (irq_o);
    c_read_clear: cover property (rd_status && |st_reg.status);
    c_ais_tx: cover property (tx_ci_active_o && tx_mode == ci_ctrl_pkg::CI_AIS);

endmodule

// [verification/line_model.sv]
// Far-end line model: bit clock ticks and received-bit strobe
`timescale 1ns/1ps
module line_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    output logic      tick_o,
    output logic      bit_valid_o
);
    logic [1:0] cnt_reg;
    // One line bit every four clocks; data is valid the cycle after a tick
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg     <= 2'h0;
            tick_o      <= 1'b0;
            bit_valid_o <= 1'b0;
        end else begin
            cnt_reg     <= cnt_reg + 2'h1;
            tick_o      <= (cnt_reg == 2'h3);
            bit_valid_o <= tick_o;
        end
    end
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the framer control register group
`timescale 1ns/1ps
module tb_top;
    localparam int        MSG_CYC = 40;
    localparam int        SIG_CYC = 8;
    logic                 clk_i = 1'b0;
    logic                 rst_i = 1'b1;
    ci_ctrl_pkg::wb_req_t req   = '0;
    ci_ctrl_pkg::wb_rsp_t rsp;
    logic                 rx_ais = 1'b0;
    logic                 rx_rai = 1'b0;
    logic                 tick, bv, irq, act, txd, aen, ren, b;
    logic [2:0]           hsel;
    logic [7:0]           q, v;
    logic [31:0]          rng = 32'h568d;
    int                   n_mismatch = 0;
    int                   cmp_count = 0;
    int                   i, ones, zeros, bad, tcnt;
    framer_irq_hdlc_ci_alarm_ctrl #(.RAI_MSG_CYCLES(MSG_CYC), .RAI_SIG_CYCLES(SIG_CYC)) framer_irq_hdlc_ci_alarm_ctrl_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .rx_ais_ci_seen_i(rx_ais),
        .rx_rai_ci_seen_i(rx_rai), .tx_bit_tick_i(tick), .irq_o(irq), .hdlc_sel_o(hsel),
        .ais_ci_detect_en_o(aen), .rai_ci_detect_en_o(ren), .tx_ci_active_o(act), .tx_ci_data_o(txd));
    line_model line_model_inst (.clk_i(clk_i), .rst_i(rst_i), .tick_o(tick), .bit_valid_o(bv));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    // ****
    // Bus, compare and model helpers
    // ****
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic results();
        if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [11:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: a, dat: {24'h0, d}};
        n = 0;
        do begin @(posedge clk_i); n++; end while (rsp.ack !== 1'b1 && n < 20);
        if (rsp.ack !== 1'b1) begin n_mismatch++; results(); end
        q = rsp.dat[7:0];
        req <= '0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk(q, e);
    endtask
    task automatic pulse(input logic a, input logic r);
        @(posedge clk_i);
        rx_ais <= a;
        rx_rai <= r;
        @(posedge clk_i);
        {rx_ais, rx_rai} <= 2'h0;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic get_bit(input logic need_bv);
        int n;
        n = 0;
        do begin @(posedge clk_i); n++; end while ((need_bv ? bv : act) !== 1'b1 && n < 50);
        if ((need_bv ? bv : act) !== 1'b1) begin n_mismatch++; results(); end
        tcnt += n;
        b = txd;
    endtask
    function automatic logic [2:0] hexp(input logic [1:0] c);
        return c == 2'h1 ? ci_ctrl_pkg::HSEL_2 : c == 2'h2 ? ci_ctrl_pkg::HSEL_3 : ci_ctrl_pkg::HSEL_1;
    endfunction
    // ****
    // Main sequence
    // ****
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 6; i++) rd(ci_ctrl_pkg::OFS_INTERRUPT_CONTROL + 12'(i * 4), ci_ctrl_pkg::RST_REG);
        chk(hsel, ci_ctrl_pkg::HSEL_1);
        for (i = 0; i < 8; i++) begin
            rng = xs(rng);
            v = (i < 4) ? 8'(i) : rng[7:0];
            wb(1'b1, 12'h114, v);
            repeat (3) @(posedge clk_i);
            chk(hsel, hexp(v[1:0]));
            wb(1'b1, 12'h118, {7'h0, v[2]});
            wb(1'b1, 12'h11c, {6'h0, v[1:0]});
            repeat (3) @(posedge clk_i);
            chk({aen, ren}, v[2] ? {v[1:0] == 2'h1, v[1:0] == 2'h2} : 2'h0);
        end
        wb(1'b1, 12'h118, 8'h01);
        wb(1'b1, 12'h11c, 8'h01);
        wb(1'b1, 12'h124, 8'h03);
        wb(1'b1, 12'h110, 8'h01);
        pulse(1'b1, 1'b1);
        chk(irq, 1'b1);
        rd(12'h120, 8'h01);
        rd(12'h120, 8'h00);
        rd(12'h124, 8'h03);
        chk(irq, 1'b0);
        wb(1'b1, 12'h11c, 8'h02);
        pulse(1'b1, 1'b1);
        rd(12'h120, 8'h02);
        wb(1'b1, 12'h11c, 8'h01);
        wb(1'b1, 12'h110, 8'h03);
        pulse(1'b1, 1'b0);
        rd(12'h120, 8'h01);
        rd(12'h124, 8'h02);
        wb(1'b1, 12'h124, 8'h01);
        wb(1'b1, 12'h110, 8'h05);
        pulse(1'b1, 1'b0);
        rd(12'h120, 8'h01);
        rd(12'h120, 8'h01);
        wb(1'b1, 12'h120, 8'h03);
        rd(12'h120, 8'h00);
        wb(1'b1, 12'h110, 8'h04);
        pulse(1'b1, 1'b0);
        chk(irq, 1'b0);
        wb(1'b1, 12'h11c, 8'h0c);
        repeat (20) @(posedge clk_i);
        chk(act, 1'b0);
        wb(1'b1, 12'h118, 8'h00);
        wb(1'b1, 12'h11c, 8'h04);
        repeat (20) @(posedge clk_i);
        chk(act, 1'b0);
        wb(1'b1, 12'h118, 8'h01);
        get_bit(1'b0);
        bad = 0;
        for (i = 0; i < 402; i++) begin
            get_bit(1'b1);
            if (b !== ((i % 386) < 16 ? ci_ctrl_pkg::AIS_CI_SIGNATURE[i % 386] : 1'b1)) bad++;
        end
        chk(bad, 0);
        wb(1'b1, 12'h11c, 8'h08);
        get_bit(1'b0);
        bad = 0;
        ones = 0;
        zeros = 0;
        tcnt = 0;
        // Zeros counts message-phase bits, ones signature-phase bits
        for (i = 0; i < 96; i++) begin
            get_bit(1'b1);
            if ((tcnt - 1) % (MSG_CYC + SIG_CYC) < MSG_CYC) begin
                zeros++;
                if (b !== ci_ctrl_pkg::RAI_MESSAGE[i % 16]) bad++;
            end else begin
                ones++;
                if (b !== ci_ctrl_pkg::RAI_CI_SIGNATURE[i % 16]) bad++;
            end
        end
        chk(bad, 0);
        chk(ones > 0 && zeros > ones, 1'b1);
        results();
    end
endmodule
